// ==== hdl/dcs_top.sv ====
// Drawing command front end: registers, launch control, image intake
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Auto-run off: command write launches; on: last parameter write launches.
// - Clip settings apply only while clip_enable is set.
// - Format 000 8-bit, 001 16-bit, 010 24-bit; others reserved.
// - pixel_write_enable low runs the command but writes no pixels.
// - Host source takes image words from the two host windows.
// - Colour pattern from memory unless mono; fills need mono pattern.
// - Transparent mono source writes only 1 bits in foreground colour.
// - Colour key skips matching pixels at 8/16 bpp, not 24.
// - Transparency acts only with host source selected.
// - Alignment 00 byte, 01 word, 10 doubleword, 11 reserved.
// - Line end: discard, reuse upper word, or continue next byte.
// - First-word skip field drops 0 to 3 leading bytes.
// - Block writes only if not disabled and global enable set.
// - Raster key selects 256 ops; fill/line/polygon must not use source.
// - Fill, line, polygon force pattern to pattern foreground colour.
// - Copy direction: x and y forward flags choose stepping order.
// - No-op written with auto-run clear leaves auto-run, draws nothing.
// - Rectangle height is a direct line count.
// - Rectangle width holds pixels minus one.
// - Corners: Y in bits 10-0, X in bits 26-16, origin 0,0.
// - Line draws span exactly first to last X end point.
module dcs_top
	import dcs_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// Wishbone classic slave
	input  wire logic [24:0] wb_adr,
	input  wire logic [31:0] wb_dat_w,
	input  wire logic [3:0]  wb_sel,
	input  wire logic        wb_we,
	input  wire logic        wb_cyc,
	input  wire logic        wb_stb,
	output logic [31:0]      wb_dat_r,
	output logic             wb_ack,
	// Drawing engine handshake
	input  wire logic        param_set_end,
	input  wire logic        engine_done,
	output logic             launch,
	output logic             busy,
	output dcs_dec_s         run_cmd,
	// Geometry of the launched command
	output logic [11:0]      run_width_px,
	output logic [10:0]      run_height,
	output logic [10:0]      run_src_x,
	output logic [10:0]      run_src_y,
	output logic [10:0]      run_dst_x,
	output logic [10:0]      run_dst_y,
	output logic [10:0]      run_first_x,
	output logic [10:0]      run_last_x,
	// Unpacked image data
	output logic             img_valid,
	output logic [31:0]      img_data,
	output logic [3:0]       img_mask,
	output logic [3:0]       img_first,
	output logic             img_done
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [31:0] cmd;
		logic [31:0] size;
		logic [31:0] src;
		logic [31:0] dst;
		logic [31:0] lxe;
		logic        gbw;
		logic        busy;
		logic        refused;
		logic        pend;
		logic [7:0]  cnt;
		logic        ack;
		logic [31:0] rdat;
		logic        launch;
		dcs_dec_s    run;
		logic [11:0] wpx;
		logic [10:0] hgt;
		logic [10:0] sx;
		logic [10:0] sy;
		logic [10:0] dx;
		logic [10:0] dy;
		logic [10:0] fx;
		logic [10:0] lx;
	} dcs_top_s;

	dcs_top_s    st;
	dcs_top_s    nxt;
	dcs_cmd_if   cbus ();
	logic        req;
	logic        wr;
	logic        img_wr;
	logic        start;
	logic [24:0] wadr;
	logic [31:0] cmd_new;
	logic [3:0]  op_now;
	logic [11:0] px;
	logic [12:0] lbytes;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] dcs_merge(
		input logic [31:0] old,
		input logic [31:0] wd,
		input logic [3:0]  sel,
		input logic [31:0] keep
	);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) r[8*b+:8] = wd[8*b+:8];
		end
		return r & keep;
	endfunction

	// ****************************************
	// Decoder and unpacker
	// ****************************************
	assign cbus.cmd = st.cmd;
	assign cbus.global_bw = st.gbw;

	dcs_decode u_decode (
		.bus (cbus.decoder)
	);

	// host words only from the two windows
	assign img_wr = wr && st.run.host_src
		&& (((wadr >= IMG_LO0) && (wadr <= IMG_HI0))
		|| ((wadr >= IMG_LO1) && (wadr <= IMG_HI1)));

	dcs_unpack u_unpack (
		.clk_sys    (clk_sys),
		.rst_n      (rst_n),
		.start      (start && cbus.dec.host_src),
		.line_bytes (lbytes),
		.rows       (st.size[XY_Y+:11]),
		.first_word_skip_field        (cbus.dec.first_word_skip_field),
		.align      (cbus.dec.align),
		.word_valid (img_wr),
		.word_data  (wb_dat_w),
		.out_valid  (img_valid),
		.out_data   (img_data),
		.out_mask   (img_mask),
		.out_first  (img_first),
		.out_done   (img_done)
	);

	// ****************************************
	// Line length in bytes
	// ****************************************
	always_comb begin
		// stored width is pixels minus one
		px = {1'b0, st.size[XY_X+:11]} + 12'd1;
		if (cbus.dec.mono_src) begin
			lbytes = {4'h0, px[11:3]} + {12'h000, (px[2:0] != 3'h0)};
		end else begin
			unique case (cbus.dec.bpp)
				2'd1: lbytes = {1'b0, px};
				2'd2: lbytes = {px, 1'b0};
				default: lbytes = {px, 1'b0} + {1'b0, px};
			endcase
		end
	end

	// ****************************************
	// Bus, launch and status logic
	// ****************************************
	always_comb begin
		nxt = st;
		nxt.ack = 1'b0;
		nxt.launch = 1'b0;
		nxt.pend = 1'b0;
		req = wb_cyc && wb_stb && !st.ack;
		wr = req && wb_we;
		wadr = {wb_adr[ADR_W-1:2], 2'b00};
		op_now = st.cmd[CMD_OP+:4];
		cmd_new = dcs_merge(st.cmd, wb_dat_w, wb_sel, MASK_CMD);
		start = st.pend && cbus.dec.valid;

		if (req) begin
			nxt.ack = 1'b1;
			nxt.rdat = '0;
			if (!wb_we) begin
				unique case (wadr)
					OFS_CMD:  nxt.rdat = st.cmd;
					OFS_SIZE: nxt.rdat = st.size;
					OFS_SRC:  nxt.rdat = st.src;
					OFS_DST:  nxt.rdat = st.dst;
					OFS_LINE: nxt.rdat = st.lxe;
					OFS_CTRL: nxt.rdat[CTRL_GBW] = st.gbw;
					OFS_STAT: begin
						nxt.rdat[STAT_BSY] = st.busy;
						nxt.rdat[STAT_REF] = st.refused;
						nxt.rdat[STAT_AUT] = st.cmd[CMD_AUTO];
						nxt.rdat[STAT_CNT+:8] = st.cnt;
					end
					default: nxt.rdat = '0;
				endcase
			end
		end

		if (wr) begin
			unique case (wadr)
				OFS_CMD:  nxt.cmd = cmd_new;
				OFS_SIZE: nxt.size = dcs_merge(st.size, wb_dat_w, wb_sel, MASK_XY);
				OFS_SRC:  nxt.src = dcs_merge(st.src, wb_dat_w, wb_sel, MASK_XY);
				OFS_DST:  nxt.dst = dcs_merge(st.dst, wb_dat_w, wb_sel, MASK_XY);
				OFS_LINE: nxt.lxe = dcs_merge(st.lxe, wb_dat_w, wb_sel, MASK_XY);
				OFS_CTRL: begin
					if (wb_sel[0]) begin
						nxt.gbw = wb_dat_w[CTRL_GBW];
						if (wb_dat_w[CTRL_CLR]) nxt.refused = 1'b0;
					end
				end
				default: nxt.gbw = st.gbw;
			endcase
		end

		// command write arms decode when auto-run clear
		if (wr && (wadr == OFS_CMD) && !cmd_new[CMD_AUTO]) begin
			nxt.pend = 1'b1;
		end
		// last parameter of the copy or fill set
		if (wr && (wadr == OFS_DST) && st.cmd[CMD_AUTO]
			&& ((op_now == OP_BLIT) || (op_now == OP_FILL))) begin
			nxt.pend = 1'b1;
		end
		// last parameter of line or polygon set
		if (param_set_end && st.cmd[CMD_AUTO]
			&& ((op_now == OP_LINE) || (op_now == OP_POLY))) begin
			nxt.pend = 1'b1;
		end

		if (engine_done) nxt.busy = 1'b0;

		if (start) begin
			nxt.launch = 1'b1;
			nxt.busy = 1'b1;
			nxt.cnt = st.cnt + 8'd1;
			nxt.run = cbus.dec;
			nxt.wpx = px;
			nxt.hgt = st.size[XY_Y+:11];
			nxt.sx = st.src[XY_X+:11];
			nxt.sy = st.src[XY_Y+:11];
			nxt.dx = st.dst[XY_X+:11];
			nxt.dy = st.dst[XY_Y+:11];
			nxt.fx = st.lxe[XY_X+:11];
			nxt.lx = st.lxe[XY_Y+:11];
		end else if (st.pend && !cbus.dec.is_nop) begin
			// reserved code leaves the engine idle
			nxt.refused = 1'b1;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign wb_dat_r = st.rdat;
	assign wb_ack = st.ack;
	assign launch = st.launch;
	assign busy = st.busy;
	assign run_cmd = st.run;
	assign run_width_px = st.wpx;
	assign run_height = st.hgt;
	assign run_src_x = st.sx;
	assign run_src_y = st.sy;
	assign run_dst_x = st.dx;
	assign run_dst_y = st.dy;
	assign run_first_x = st.fx;
	assign run_last_x = st.lx;

endmodule
`default_nettype wire

// ==== hdl/dcs_pkg.sv ====
// Shared constants and types of the drawing command front end
package dcs_pkg;

	// ****************************************
	// Bus and address map
	// ****************************************
	localparam int unsigned ADR_W = 25;
	localparam logic [24:0] OFS_CMD  = 25'h000A500;
	localparam logic [24:0] OFS_SIZE = 25'h000A504;
	localparam logic [24:0] OFS_SRC  = 25'h000A508;
	localparam logic [24:0] OFS_DST  = 25'h000A50C;
	localparam logic [24:0] OFS_CTRL = 25'h000A510;
	localparam logic [24:0] OFS_STAT = 25'h000A514;
	localparam logic [24:0] OFS_LINE = 25'h000A96C;
	localparam logic [24:0] IMG_LO0  = 25'h1000000;
	localparam logic [24:0] IMG_HI0  = 25'h1007FFF;
	localparam logic [24:0] IMG_LO1  = 25'h100D000;
	localparam logic [24:0] IMG_HI1  = 25'h100EFFF;
	localparam logic [24:0] PAT_BASE = 25'h100A100;

	// ****************************************
	// Field layouts and reset values
	// ****************************************
	localparam logic [31:0] MASK_CMD = 32'hFFFF3FFF;
	localparam logic [31:0] MASK_XY  = 32'h07FF07FF;
	localparam logic [31:0] RST_REG  = 32'h00000000;
	localparam int unsigned CMD_AUTO = 0;
	localparam int unsigned CMD_CLIP = 1;
	localparam int unsigned CMD_FMT  = 2;
	localparam int unsigned CMD_DE   = 5;
	localparam int unsigned CMD_MS   = 6;
	localparam int unsigned CMD_IDS  = 7;
	localparam int unsigned CMD_MP   = 8;
	localparam int unsigned CMD_TP   = 9;
	localparam int unsigned CMD_ITA  = 10;
	localparam int unsigned CMD_FDO  = 12;
	localparam int unsigned CMD_BWD  = 16;
	localparam int unsigned CMD_ROP  = 17;
	localparam int unsigned CMD_XP   = 25;
	localparam int unsigned CMD_YP   = 26;
	localparam int unsigned CMD_OP   = 27;
	localparam int unsigned CMD_DIM  = 31;
	localparam int unsigned XY_Y     = 0;
	localparam int unsigned XY_X     = 16;
	localparam int unsigned CTRL_GBW = 0;
	localparam int unsigned CTRL_CLR = 1;
	localparam int unsigned STAT_BSY = 0;
	localparam int unsigned STAT_REF = 1;
	localparam int unsigned STAT_AUT = 2;
	localparam int unsigned STAT_CNT = 8;

	// ****************************************
	// Codes
	// ****************************************
	typedef enum logic [3:0] {
		OP_BLIT = 4'h0,
		OP_FILL = 4'h2,
		OP_LINE = 4'h3,
		OP_POLY = 4'h5,
		OP_NOP  = 4'hF
	} dcs_op_e;
	localparam logic [2:0] FMT_8  = 3'h0;
	localparam logic [2:0] FMT_16 = 3'h1;
	localparam logic [2:0] FMT_24 = 3'h2;
	localparam logic [1:0] AL_BYTE  = 2'h0;
	localparam logic [1:0] AL_WORD  = 2'h1;
	localparam logic [1:0] AL_DWORD = 2'h2;
	localparam logic [1:0] AL_RSVD  = 2'h3;

	typedef struct packed {
		logic       valid;
		logic       is_nop;
		logic [3:0] op;
		logic [2:0] fmt;
		logic [1:0] bpp;
		logic       clip_en;
		logic       draw_en;
		logic       host_src;
		logic       mono_src;
		logic       pat_mono;
		logic       pat_from_mem;
		logic       force_pat_fg;
		logic       mono_see_through;
		logic       color_key;
		logic [1:0] align;
		logic [1:0] first_word_skip_field;
		logic       block_write;
		logic [7:0] rop;
		logic       x_fwd;
		logic       y_fwd;
	} dcs_dec_s;

endpackage

// ==== hdl/dcs_cmd_if.sv ====
// Command word and its decoded fields between top and decoder
`timescale 1ns/10ps
`default_nettype none
interface dcs_cmd_if;
	import dcs_pkg::*;
	logic [31:0] cmd;
	logic        global_bw;
	dcs_dec_s    dec;
	modport owner (output cmd, output global_bw, input dec);
	modport decoder (input cmd, input global_bw, output dec);
endinterface
`default_nettype wire

// ==== hdl/dcs_decode.sv ====
// Combinational decode of the drawing command word
`timescale 1ns/10ps
`default_nettype none
module dcs_decode
	import dcs_pkg::*;
(
	// Command carrier
	dcs_cmd_if.decoder bus
);
	logic [31:0] c;
	logic [3:0]  op;
	logic        blit;
	logic        solid;
	logic        rop_src;
	logic        rop_pat;
	logic        see;

	always_comb begin
		c = bus.cmd;
		op = c[CMD_OP+:4];
		blit = (op == OP_BLIT);
		solid = (op == OP_FILL) || (op == OP_LINE) || (op == OP_POLY);
		rop_src = (c[CMD_ROP+6+:2] != c[CMD_ROP+4+:2]) || (c[CMD_ROP+2+:2] != c[CMD_ROP+:2]);
		rop_pat = (c[CMD_ROP+4+:4] != c[CMD_ROP+:4]);
		see = c[CMD_TP] & c[CMD_IDS];
		bus.dec = '0;
		bus.dec.op = op;
		bus.dec.fmt = c[CMD_FMT+:3];
		bus.dec.rop = c[CMD_ROP+:8];
		bus.dec.is_nop = (op == OP_NOP) && !c[CMD_DIM];
		// refuse sourced key or reserved code
		bus.dec.valid = !c[CMD_DIM] && (blit || (solid && !rop_src))
			&& (c[CMD_FMT+:3] <= FMT_24) && (c[CMD_ITA+:2] != AL_RSVD);
		bus.dec.bpp = (c[CMD_FMT+:3] == FMT_8) ? 2'd1 : (c[CMD_FMT+:3] == FMT_16) ? 2'd2 : 2'd3;
		bus.dec.clip_en = c[CMD_CLIP];
		bus.dec.draw_en = c[CMD_DE];
		bus.dec.host_src = c[CMD_IDS];
		bus.dec.mono_src = c[CMD_MS];
		bus.dec.pat_mono = c[CMD_MP] | solid;
		bus.dec.pat_from_mem = blit & !c[CMD_MP] & rop_pat;
		bus.dec.force_pat_fg = solid & rop_pat;
		bus.dec.mono_see_through = see & c[CMD_MS];
		bus.dec.color_key = see & !c[CMD_MS] & (c[CMD_FMT+:3] != FMT_24);
		bus.dec.align = c[CMD_ITA+:2];
		bus.dec.first_word_skip_field = c[CMD_FDO+:2];
		bus.dec.block_write = !c[CMD_BWD] & bus.global_bw;
		bus.dec.x_fwd = blit ? c[CMD_XP] : 1'b1;
		bus.dec.y_fwd = blit ? c[CMD_YP] : 1'b1;
	end
endmodule
`default_nettype wire

// ==== hdl/dcs_unpack.sv ====
// Image doubleword unpacker: line alignment and first-word skip
`timescale 1ns/10ps
`default_nettype none
module dcs_unpack
	import dcs_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// Image setup
	input  wire logic        start,
	input  wire logic [12:0] line_bytes,
	input  wire logic [10:0] rows,
	input  wire logic [1:0]  first_word_skip_field,
	input  wire logic [1:0]  align,
	// Host words in
	input  wire logic        word_valid,
	input  wire logic [31:0] word_data,
	// Bytes out
	output logic             out_valid,
	output logic [31:0]      out_data,
	output logic [3:0]       out_mask,
	output logic [3:0]       out_first,
	output logic             out_done
);
	typedef struct packed {
		logic        active;
		logic [12:0] lb;
		logic [12:0] rem;
		logic [10:0] rows;
		logic [1:0]  skip;
		logic [1:0]  align;
		logic        valid;
		logic [31:0] data;
		logic [3:0]  mask;
		logic [3:0]  first;
		logic        done;
	} dcs_unp_s;
	dcs_unp_s st;
	dcs_unp_s nxt;

	always_comb begin
		logic [12:0] rem;
		logic [10:0] rws;
		logic [1:0]  sk;
		logic        live;
		logic        brk;
		rem = st.rem;
		rws = st.rows;
		sk = st.skip;
		live = st.active;
		brk = 1'b0;
		nxt = st;
		nxt.valid = 1'b0;
		nxt.done = 1'b0;
		if (start) begin
			nxt.lb = line_bytes;
			nxt.rem = line_bytes;
			nxt.rows = rows;
			nxt.skip = first_word_skip_field;
			nxt.align = align;
			nxt.active = (rows != 11'd0) && (line_bytes != 13'd0);
		end else if (word_valid && st.active) begin
			nxt.valid = 1'b1;
			nxt.data = word_data;
			nxt.mask = '0;
			nxt.first = '0;
			for (int i = 0; i < 4; i++) begin
				if (live && !brk && (2'(i) >= sk)) begin
					nxt.mask[i] = 1'b1;
					nxt.first[i] = (rem == st.lb);
					rem = rem - 13'd1;
					if (rem == 13'd0) begin
						rem = st.lb;
						rws = rws - 11'd1;
						live = (rws != 11'd0);
						unique case (st.align)
							AL_DWORD: brk = 1'b1;
							AL_WORD: begin
								if (i < 2) sk = 2'd2;
								else brk = 1'b1;
							end
							default: brk = 1'b0;
						endcase
					end
				end
			end
			nxt.rem = rem;
			nxt.rows = rws;
			nxt.skip = 2'd0;
			nxt.active = live;
			nxt.done = ~live;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) st <= '0;
		else st <= nxt;
	end

	assign out_valid = st.valid;
	assign out_data = st.data;
	assign out_mask = st.mask;
	assign out_first = st.first;
	assign out_done = st.done;
endmodule
`default_nettype wire

// ==== tb/dcs_props.sv ====
// Port checker of the drawing command front end
`timescale 1ns/10ps
`default_nettype none
module dcs_props
	import dcs_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// Register bus
	input  wire logic [24:0] wb_adr,
	input  wire logic [31:0] wb_dat_w,
	input  wire logic        wb_we,
	input  wire logic        wb_cyc,
	input  wire logic        wb_stb,
	input  wire logic [31:0] wb_dat_r,
	input  wire logic        wb_ack,
	// Engine side
	input  wire logic        param_set_end,
	input  wire logic        engine_done,
	input  wire logic        launch,
	input  wire logic        busy,
	input  wire dcs_dec_s    run_cmd,
	input  wire logic        img_valid,
	input  wire logic        img_done
);
	logic [31:0] cmd_r;
	logic        take;

	// Legal command: known 2D op, format, alignment, no source key for fills
	function automatic logic ok(input logic [31:0] c);
		logic [3:0] o;
		logic [7:0] k;
		o = c[30:27];
		k = c[24:17];
		return !c[31] && c[4:2] <= 3'h2 && c[11:10] != 2'h3 && (o == 4'h0 ||
			((o == 4'h2 || o == 4'h3 || o == 4'h5) && k[7:6] == k[5:4] && k[3:2] == k[1:0]));
	endfunction

	assign take = wb_cyc && wb_stb && !wb_ack && wb_we;
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cmd_r <= 32'h00000000;
		end else if (take && wb_adr == OFS_CMD) begin
			cmd_r <= wb_dat_w;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_ack_next: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
		else $error("request not acknowledged");
	a_ack_pulse: assert property (wb_ack |=> !wb_ack) else $error("ack longer than one cycle");
	a_cmd_start: assert property (
		take && wb_adr == OFS_CMD && !wb_dat_w[0] && ok(wb_dat_w) |-> ##2 launch)
		else $error("command write did not start");
	a_nop_idle: assert property (
		take && wb_adr == OFS_CMD && !wb_dat_w[0] && wb_dat_w[30:27] == 4'hF |-> ##2 !launch)
		else $error("no-op started a command");
	a_rsvd_idle: assert property (take && wb_adr == OFS_CMD && !ok(wb_dat_w) |-> ##2 !launch)
		else $error("reserved command started");
	a_dst_start: assert property (
		take && wb_adr == OFS_DST && cmd_r[0] && ok(cmd_r) && !cmd_r[27] |-> ##2 launch)
		else $error("corner write did not start");
	a_set_end: assert property (
		param_set_end && cmd_r[0] && ok(cmd_r) && cmd_r[27] |-> ##[1:2] launch)
		else $error("set end did not start");
	a_busy_fall: assert property (busy && engine_done && !launch |=> !busy)
		else $error("busy not cleared");
	a_run_hold: assert property (!launch |-> $stable(run_cmd)) else $error("run command moved");
	a_fwd_other: assert property (
		launch && run_cmd.op != OP_BLIT |-> run_cmd.x_fwd && run_cmd.y_fwd)
		else $error("direction on non-copy");
	a_decode_flds: assert property (launch |-> busy && run_cmd.clip_en == cmd_r[1] &&
		run_cmd.draw_en == cmd_r[5] && run_cmd.rop == cmd_r[24:17] && run_cmd.fmt == cmd_r[4:2])
		else $error("decoded fields wrong");
	a_img_ack: assert property (img_valid |-> wb_ack) else $error("image word without ack");
	a_done_word: assert property (img_done |-> img_valid) else $error("done without word");
	a_unmapped_zero: assert property (wb_cyc && wb_stb && !wb_ack && !wb_we &&
		wb_adr == 25'h000A5F0 |=> wb_dat_r == 32'h00000000) else $error("unmapped read not 0");

	c_auto_run: cover property (launch && cmd_r[0]);
	c_img_done: cover property (img_done);
	c_nop: cover property (take && wb_adr == OFS_CMD && wb_dat_w[30:27] == 4'hF);
endmodule
`default_nettype wire

// ==== tb/dcs_engine_model.sv ====
// Pixel engine stand-in: finishes commands and marks set ends
`timescale 1ns/10ps
`default_nettype none
module dcs_engine_model (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_n,
	// Front end side
	input  wire logic launch,
	input  wire logic slow,
	input  wire logic set_req,
	output logic      engine_done,
	output logic      param_set_end
);
	logic [3:0] cnt_r;
	logic       run_r;

	// A relaunch restarts the count, dropping the old job
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			{cnt_r, run_r, engine_done, param_set_end} <= 7'h00;
		end else begin
			param_set_end <= set_req;
			engine_done <= run_r && cnt_r == 4'h0;
			if (launch) begin
				run_r <= 1'b1;
				cnt_r <= slow ? 4'hC : 4'h1;
			end else if (run_r) begin
				run_r <= cnt_r != 4'h0;
				cnt_r <= cnt_r - 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== tb/dcs_top_bench.sv ====
// Self-checking bench of the drawing command front end
`timescale 1ns/10ps
`default_nettype none
module dcs_top_bench
	import dcs_pkg::*;
;
	typedef struct packed {
		logic [3:0]  op;
		logic [2:0]  fmt;
		logic [7:0]  rop;
		logic [10:0] flg;
		logic [1:0]  al;
		logic [1:0]  first_word_skip_field;
		logic [11:0] w;
		logic [10:0] h;
		logic [65:0] xy;
	} dcs_exp_s;
	localparam logic [24:0] RA[4] = '{OFS_SIZE, OFS_SRC, OFS_DST, OFS_LINE};
	localparam logic [3:0]  OPS[4] = '{OP_BLIT, OP_FILL, OP_LINE, OP_POLY};
	logic        clk_sys, rst_n, wb_we, wb_cyc, wb_stb, wb_ack, launch, busy, gbw;
	logic        param_set_end, engine_done, img_valid, img_done, slow, set_req;
	logic [24:0] wb_adr;
	logic [31:0] wb_dat_w, wb_dat_r, img_data, seed, c;
	logic [3:0]  wb_sel, img_mask, img_first;
	logic [11:0] run_width_px;
	logic [10:0] run_height, run_src_x, run_src_y, run_dst_x, run_dst_y, run_first_x, run_last_x;
	logic [7:0]  nl, k;
	dcs_dec_s    run_cmd;
	logic [31:0] gv[4];
	int          miscompares, compares, cyc_n;
	logic [31:0] rd_q[$];
	dcs_exp_s    ln_q[$];
	logic [40:0] im_q[$];

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	dcs_top i_dut (.clk_sys, .rst_n, .wb_adr, .wb_dat_w, .wb_sel, .wb_we, .wb_cyc, .wb_stb,
		.wb_dat_r, .wb_ack, .param_set_end, .engine_done, .launch, .busy, .run_cmd,
		.run_width_px, .run_height, .run_src_x, .run_src_y, .run_dst_x, .run_dst_y,
		.run_first_x, .run_last_x, .img_valid, .img_data, .img_mask, .img_first, .img_done);
	dcs_engine_model i_eng (.clk_sys, .rst_n, .launch, .slow, .set_req, .engine_done,
		.param_set_end);

	task automatic fail(input string m);
		miscompares++;
		$display("[FAIL] %0t %s", $time, m);
	endtask
	task automatic report_and_stop();
		if (miscompares == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic cmp_rd(input logic [31:0] e, input logic [31:0] a);
		compares++;
		if (a !== e) fail("read data");
	endtask
	task automatic cmp_run(input dcs_exp_s e, input dcs_exp_s a);
		compares++;
		if (a !== e) fail("launched command");
	endtask
	task automatic cmp_img(input logic [40:0] e, input logic [40:0] a);
		compares++;
		if (a !== e) fail("image word");
	endtask

	// Results are matched against the oldest expectation
	always @(posedge clk_sys) begin
		if (rst_n && wb_ack && !wb_we && rd_q.size() > 0) cmp_rd(rd_q.pop_front(), wb_dat_r);
		if (rst_n && launch) begin
			if (ln_q.size() == 0) fail("stray launch");
			else cmp_run(ln_q.pop_front(), '{run_cmd.op, run_cmd.fmt, run_cmd.rop,
				{run_cmd.host_src, run_cmd.mono_src, run_cmd.pat_mono, run_cmd.force_pat_fg,
				run_cmd.clip_en, run_cmd.draw_en, run_cmd.x_fwd, run_cmd.y_fwd,
				run_cmd.block_write, run_cmd.mono_see_through, run_cmd.color_key},
				run_cmd.align, run_cmd.first_word_skip_field, run_width_px, run_height, {run_dst_x, run_dst_y,
				run_src_x, run_src_y, run_first_x, run_last_x}});
		end
		if (rst_n && img_valid) begin
			if (im_q.size() == 0) fail("stray image word");
			else cmp_img(im_q.pop_front(), {img_data, img_mask, img_first, img_done});
		end
		cyc_n++;
		if (cyc_n > 20000) begin
			fail("timeout");
			report_and_stop();
		end
	end

	task automatic bus(input logic [24:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		if (!w) rd_q.push_back(d);
		wb_adr <= a;
		wb_we <= w;
		wb_dat_w <= d;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (wb_ack !== 1'b1 && n < 50);
		if (n >= 50) fail("no ack");
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clk_sys);
	endtask

	function automatic logic [31:0] mkc(input logic [3:0] op, input logic [2:0] f,
		input logic [7:0] kk, input logic [3:0] lo, input logic [1:0] al, input logic au);
		logic [6:0] r;
		r = 7'($urandom);
		return {1'b0, op, r[1:0], kk, r[2], 2'h0, r[4:3], al, lo, r[5], f, r[6], au};
	endfunction

	task automatic expect_run(input logic [31:0] x);
		ln_q.push_back('{x[30:27], x[4:2], x[24:17], {x[7], x[6], x[8] || x[30:27] != 4'h0,
			x[30:27] != 4'h0 && x[24:21] != x[20:17], x[1], x[5], x[30:27] != 4'h0 || x[25],
			x[30:27] != 4'h0 || x[26], !x[16] && gbw, x[7] && x[9] && x[6],
			x[7] && x[9] && !x[6] && x[4:2] != FMT_24}, x[11:10], x[13:12],
			{1'b0, gv[0][26:16]} + 12'h001, gv[0][10:0], {gv[2][26:16], gv[2][10:0],
			gv[1][26:16], gv[1][10:0], gv[3][26:16], gv[3][10:0]}});
		nl++;
	endtask
	task automatic cmd(input logic [31:0] x, input logic go);
		if (go) expect_run(x);
		bus(OFS_CMD, 1'b1, x);
	endtask
	task automatic img_cmd(input logic ms, input logic [2:0] f, input logic [1:0] al,
		input logic [1:0] fd, input logic [10:0] w, input logic [10:0] h);
		gv[0] = {5'h00, w, 5'h00, h};
		bus(OFS_SIZE, 1'b1, gv[0]);
		c = mkc(OP_BLIT, f, 8'hCC, {3'h1, ms}, al, 1'b0);
		c[13:12] = fd;
		cmd(c, 1'b1);
	endtask
	task automatic img_word(input logic [24:0] a, input logic [3:0] m, input logic [3:0] f,
		input logic d);
		logic [31:0] v;
		v = $urandom;
		if (m != 4'h0) im_q.push_back({v, m, f, d});
		bus(a, 1'b1, v);
	endtask

	initial begin
		{rst_n, wb_we, wb_cyc, wb_stb, slow, set_req, gbw} = 7'h00;
		wb_adr = 25'h0000000;
		wb_dat_w = 32'h00000000;
		wb_sel = 4'hF;
		nl = 8'h00;
		seed = $urandom(32'hF1F71D8B);
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		bus(OFS_CMD, 1'b0, RST_REG);
		bus(25'h000A5F0, 1'b0, 32'h00000000);
		for (int i = 0; i < 4; i++) begin
			gv[i] = $urandom;
			bus(RA[i], 1'b1, gv[i]);
			gv[i] &= MASK_XY;
			bus(RA[i], 1'b0, gv[i]);
		end
		for (int i = 0; i < 24; i++) begin
			gbw = 1'($urandom);
			bus(OFS_CTRL, 1'b1, {31'h0, gbw});
			k = 8'($urandom);
			if (i % 4 != 0) k = {k[7:6], k[7:6], k[1:0], k[1:0]};
			c = mkc(OPS[i % 4], 3'(i % 3), k, {1'($urandom), i % 4 != 0, 2'($urandom)},
				2'(i % 3), 1'b0);
			if (i % 12 == 0) c[16] = 1'b1;
			cmd(c, 1'b1);
		end
		for (int j = 0; j < 20; j++) begin
			c = mkc(j < 16 ? 4'(j) : OP_BLIT, FMT_16, 8'hF0, 4'h4, AL_DWORD, 1'b0);
			if (j == 16) c[31] = 1'b1;
			if (j == 17) c[4:2] = 3'h3;
			if (j == 18) c[11:10] = AL_RSVD;
			if (j == 19) c[30:17] = {OP_FILL, c[26:25], 8'hCC};
			cmd(c, j == 0 || j == 2 || j == 3 || j == 5);
		end
		bus(OFS_STAT, 1'b0, {16'h0000, nl, 8'h02});
		gbw = 1'b0;
		bus(OFS_CTRL, 1'b1, 32'h00000002);
		c = mkc(OP_BLIT, FMT_8, 8'hCC, 4'h0, AL_DWORD, 1'b1);
		cmd(c, 1'b0);
		for (int j = 0; j < 2; j++) begin
			gv[2] = $urandom & MASK_XY;
			expect_run(c);
			bus(OFS_DST, 1'b1, gv[2]);
		end
		for (int j = 0; j < 2; j++) begin
			c = mkc(j ? OP_LINE : OP_BLIT, FMT_24, 8'hF0, 4'h4, AL_DWORD, 1'b1);
			if (j) cmd(c, 1'b0);
			if (j) expect_run(c);
			set_req <= 1'b1;
			@(posedge clk_sys);
			set_req <= 1'b0;
			repeat (8) @(posedge clk_sys);
		end
		bus(OFS_STAT, 1'b0, {16'h0000, nl, 8'h04});
		cmd(mkc(OP_NOP, FMT_8, 8'h00, 4'h0, AL_DWORD, 1'b0), 1'b0);
		bus(OFS_DST, 1'b1, gv[2]);
		bus(OFS_STAT, 1'b0, {16'h0000, nl, 8'h00});
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		gv = '{default: 32'h00000000};
		nl = 8'h00;
		bus(OFS_DST, 1'b0, RST_REG);
		slow <= 1'b1;
		img_cmd(1'b0, FMT_8, AL_DWORD, 2'h1, 11'd3, 11'd2);
		img_word(IMG_LO0, 4'hE, 4'h2, 1'b0);
		img_word(IMG_HI0, 4'h1, 4'h0, 1'b0);
		img_word(IMG_LO1, 4'hF, 4'h1, 1'b1);
		img_word(IMG_HI1, 4'h0, 4'h0, 1'b0);
		img_cmd(1'b1, FMT_8, AL_BYTE, 2'h2, 11'd15, 11'd3);
		img_word(IMG_HI0, 4'hC, 4'h4, 1'b0);
		img_word(IMG_LO1, 4'hF, 4'h5, 1'b1);
		img_cmd(1'b0, FMT_16, AL_WORD, 2'h0, 11'd2, 11'd2);
		img_word(IMG_LO0, 4'hF, 4'h1, 1'b0);
		img_word(IMG_LO0, 4'hF, 4'h4, 1'b0);
		img_word(IMG_LO0, 4'hF, 4'h0, 1'b1);
		repeat (20) @(posedge clk_sys);
		if (ln_q.size() + im_q.size() + rd_q.size() != 0) fail("missing result");
		report_and_stop();
	end
endmodule

bind dcs_top dcs_props u_props (.clk_sys, .rst_n, .wb_adr, .wb_dat_w, .wb_we, .wb_cyc,
	.wb_stb, .wb_dat_r, .wb_ack, .param_set_end, .engine_done, .launch, .busy, .run_cmd,
	.img_valid, .img_done);
`default_nettype wire
